// *** design/flash_security_pkg.sv ***
// Package with constants and carrier types for the flash security interlock.
package flash_security_pkg;
  // ==========================================================================
  // Security word layout.
  localparam int WORD_W = 16;
  localparam int ADDR_W = 15;
  localparam logic [ADDR_W-1:0] SEC_WORD_ADDR = 15'h7FF7;
  localparam logic [WORD_W-1:0] SEC_CODE_SECURED = 16'h0002;
  localparam logic [WORD_W-1:0] SEC_CODE_UNSECURED = 16'h0000;
  localparam logic [WORD_W-1:0] ERASED_WORD = 16'hFFFF;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;

  // ==========================================================================
  // Sampler states.
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_FETCH = 3'b010,
    ST_DONE = 3'b100
  } sec_state_t;

  // ==========================================================================
  // Debug request and answer carriers.
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } dbg_req_t;

  typedef struct packed {
    logic valid;
    logic refused;
    logic [WORD_W-1:0] data;
  } dbg_rsp_t;
endpackage

// *** design/flash_word_store.sv ***
// Non-volatile word array model with program (1 to 0 only) and mass erase.
`timescale 1ns/1ns
`default_nettype none
module flash_word_store
  import flash_security_pkg::*;
(
  input wire logic clk,                    // System clock.
  input wire logic rst_n,                  // Synchronous reset, active low.
  input wire logic progEn,                 // Program strobe.
  input wire logic [ADDR_W-1:0] progAddr,  // Program address.
  input wire logic [WORD_W-1:0] progData,  // Program data.
  input wire logic eraseEn,                // Mass erase strobe.
  input wire logic [ADDR_W-1:0] rdAddr,    // Read address.
  output logic [WORD_W-1:0] rdData         // Registered read data.
);
  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [WORD_W-1:0] rdData_d;

  // ==========================================================================
  // Array contents are not touched by reset, so they survive every reset.
  always_ff @(posedge clk) begin
    if (eraseEn) begin
      for (int i = 0; i < (1<<ADDR_W); i++) begin
        mem[i] <= ERASED_WORD;
      end
    end else if (progEn) begin
      mem[progAddr] <= mem[progAddr] & progData;
    end
  end

  always_comb begin
    rdData_d = mem[rdAddr];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData <= ERASED_WORD;
    end else begin
      rdData <= rdData_d;
    end
  end
endmodule // flash_word_store
`default_nettype wire

// *** design/flash_security_lock.sv ***
// Flash security interlock: samples the security word and gates debug reads.
`timescale 1ns/1ns
`default_nettype none
module flash_security_lock
  import flash_security_pkg::*;
(
  input wire logic clk,                    // System clock, 25 MHz.
  input wire logic rst_n,                  // Synchronous reset, active low.
  input wire logic progEn,                 // Firmware program strobe.
  input wire logic [ADDR_W-1:0] progAddr,  // Firmware program address.
  input wire logic [WORD_W-1:0] progData,  // Firmware program data.
  input wire logic eraseEn,                // Mass erase strobe.
  input wire dbg_req_t dbgReq,             // Debug read request (pin side).
  output dbg_rsp_t dbgRsp,                 // Debug read answer.
  output logic secured,                    // Device secured indication.
  output logic secValid                    // Security word has been sampled.
);
  // ==========================================================================
  // Debug request synchroniser (from the test port, another domain).
  dbg_req_t reqMeta_q, reqMeta_d;
  dbg_req_t reqSync_q, reqSync_d;

  always_comb begin
    reqMeta_d = dbgReq;
    reqSync_d = reqMeta_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reqMeta_q <= '0;
      reqSync_q <= '0;
    end else begin
      reqMeta_q <= reqMeta_d;
      reqSync_q <= reqSync_d;
    end
  end

  // ==========================================================================
  // Flash array.
  logic [ADDR_W-1:0] rdAddr;
  logic [WORD_W-1:0] rdData;

  flash_word_store u_store (
    .clk(clk),
    .rst_n(rst_n),
    .progEn(progEn),
    .progAddr(progAddr),
    .progData(progData),
    .eraseEn(eraseEn),
    .rdAddr(rdAddr),
    .rdData(rdData)
  );

  // ==========================================================================
  // Security sampler and debug gate state.
  sec_state_t state_q;
  sec_state_t state_d;
  logic secured_q;
  logic secured_d;
  logic secValid_q;
  logic secValid_d;
  logic pend_q;
  logic pend_d;
  logic dbgBusy_q;
  logic dbgBusy_d;
  dbg_rsp_t rsp_q;
  dbg_rsp_t rsp_d;
  logic dbgNew;
  logic arrayChange;
  logic sampleNow;
  logic gateOpen;
  logic grantRead;
  logic refuseNew;
  logic refusePend;

  // ==========================================================================
  // Request qualifiers.
  // A request is taken on the rising edge of its synchronised valid.
  assign dbgNew = reqSync_q.valid && !dbgBusy_q;

  // Any program or erase makes the sampled word stale.
  assign arrayChange = eraseEn || progEn;

  // The word read during ST_FETCH is judged in the first ST_DONE cycle.
  assign sampleNow = (state_q == ST_DONE) && !secValid_q;

  // Reads pass only with a fresh unsecured sample that is not changing.
  assign gateOpen = (state_q == ST_DONE) && secValid_q && !secured_q &&
    !arrayChange;

  // The gate is checked again when the data comes back, so a program
  // that lands between request and answer still turns the answer away.
  assign grantRead = dbgNew && gateOpen;
  assign refuseNew = dbgNew && !gateOpen;
  assign refusePend = pend_q && !gateOpen;

  // ==========================================================================
  // Security word sampler.
  // The sampler restarts on every reset and on every array change, so the
  // lock always follows the stored word and never a volatile copy of it.
  // Until the fresh word has been judged the device counts as secured.
  always_comb begin
    state_d = state_q;
    secured_d = secured_q;
    secValid_d = secValid_q;
    case (state_q)
      ST_RESET: begin
        secured_d = 1'b1;
        secValid_d = 1'b0;
        state_d = ST_FETCH;
      end
      ST_FETCH: begin
        // A change at this edge is missed by the read, so start over.
        if (arrayChange) begin
          state_d = ST_RESET;
        end else begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        if (arrayChange) begin
          // Drop back to the safe state until the new word is read.
          secured_d = 1'b1;
          secValid_d = 1'b0;
          state_d = ST_RESET;
        end else if (sampleNow) begin
          // Only the exact securing code locks; any other value is open.
          secured_d = (rdData == SEC_CODE_SECURED);
          secValid_d = 1'b1;
        end
      end
      default: begin
        // An illegal state code falls back to the safe state.
        secured_d = 1'b1;
        secValid_d = 1'b0;
        state_d = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_RESET;
      secured_q <= 1'b1;
      secValid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      secured_q <= secured_d;
      secValid_q <= secValid_d;
    end
  end

  // ==========================================================================
  // Array read address.
  // The security word is the idle address, so a sample never waits for it.
  always_comb begin
    rdAddr = SEC_WORD_ADDR;
    if (grantRead) begin
      rdAddr = reqSync_q.addr;
    end
  end

  // ==========================================================================
  // Debug request tracking.
  // A granted request is pending for the one cycle the array read takes.
  always_comb begin
    dbgBusy_d = reqSync_q.valid;
    pend_d = grantRead;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dbgBusy_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      dbgBusy_q <= dbgBusy_d;
      pend_q <= pend_d;
    end
  end

  // ==========================================================================
  // Debug answer.
  // A refused answer carries no data, whatever the array read returned.
  always_comb begin
    rsp_d = '0;
    if (refuseNew || refusePend) begin
      rsp_d.valid = 1'b1;
      rsp_d.refused = 1'b1;
    end else if (pend_q) begin
      rsp_d.valid = 1'b1;
      rsp_d.data = rdData;
    end
  end

  // Each answer stands for one cycle only.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // ==========================================================================
  // Outputs.
  // Every output comes straight from a register.
  assign dbgRsp = rsp_q;
  assign secured = secured_q;
  assign secValid = secValid_q;
endmodule // flash_security_lock
`default_nettype wire

// *** bench/flash_security_lock_props.sv ***
// Checker of the flash security interlock ports.
`timescale 1ns/1ns
`default_nettype none
module flash_security_lock_props
  import flash_security_pkg::*;
(
  input wire logic clk, // Clock.
  input wire logic rst_n, // Reset.
  input wire logic progEn, // Program.
  input wire logic eraseEn, // Erase.
  input wire dbg_rsp_t dbgRsp, // Answer.
  input wire logic secured, // Lock.
  input wire logic secValid // Sampled.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_open; secValid && !secured; endsequence
  sequence s_calm; (!progEn && !eraseEn)[*2]; endsequence
  sequence s_quiet; (!progEn && !eraseEn)[*3]; endsequence
  property p_ref; dbgRsp.valid && !dbgRsp.refused |-> !secured; endproperty
  property p_zero; dbgRsp.valid && dbgRsp.refused |-> dbgRsp.data == '0;
  endproperty
  property p_drop; progEn || eraseEn |=> !secValid; endproperty
  property p_back; $fell(secValid) ##1 s_calm |=> secValid; endproperty
  property p_safe; !secValid |-> secured; endproperty
  property p_erase; eraseEn ##1 s_quiet |=> s_open; endproperty
  a_ref: assert property (p_ref)
    else $error("read served while locked");
  a_zero: assert property (p_zero)
    else $error("refused answer carries data");
  a_drop: assert property (p_drop)
    else $error("word change not resampled");
  a_back: assert property (p_back)
    else $error("resample late");
  a_safe: assert property (p_safe)
    else $error("unlocked before sample");
  a_erase: assert property (p_erase)
    else $error("erase kept lock");
endmodule // flash_security_lock_props
bind flash_security_lock flash_security_lock_props i_props (.clk(clk),
  .rst_n(rst_n), .progEn(progEn), .eraseEn(eraseEn), .dbgRsp(dbgRsp),
  .secured(secured), .secValid(secValid));
`default_nettype wire

// *** bench/debug_host.sv ***
// Debug host model reading words over the debug port.
`timescale 1ns/1ns
`default_nettype none
module debug_host
  import flash_security_pkg::*;
(
  input wire logic clk, // Clock.
  output var dbg_req_t dbgReq, // Request.
  input wire dbg_rsp_t dbgRsp // Answer.
);
  initial dbgReq = '0;
  task automatic rd(input logic [ADDR_W-1:0] a, output dbg_rsp_t r);
    r = '0;
    @(posedge clk);
    dbgReq <= '{valid: 1'b1, addr: a};
    for (int i = 0; i < 8 && !r.valid; i++) begin
      @(posedge clk);
      r = dbgRsp;
    end
    dbgReq <= '{valid: 1'b0, addr: ~a};
    repeat (4) @(posedge clk);
  endtask
endmodule // debug_host
`default_nettype wire

// *** bench/tb_top.sv ***
// Testbench of the flash security interlock.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import flash_security_pkg::*;
  logic clk = 0, rst_n = 0, progEn = 0, eraseEn = 0, secured, secValid;
  logic [ADDR_W-1:0] progAddr = '0;
  logic [WORD_W-1:0] progData = '0;
  dbg_req_t dbgReq;
  dbg_rsp_t dbgRsp, r;
  int badCount = 0, checksDone = 0;
  always #20 clk = ~clk;
  flash_security_lock i_dut (.clk(clk), .rst_n(rst_n), .progEn(progEn),
    .progAddr(progAddr), .progData(progData), .eraseEn(eraseEn),
    .dbgReq(dbgReq), .dbgRsp(dbgRsp), .secured(secured),
    .secValid(secValid));
  debug_host i_host (.clk(clk), .dbgReq(dbgReq), .dbgRsp(dbgRsp));
  task automatic chk(string n, logic [17:0] s, logic [17:0] e);
    checksDone++;
    if (s !== e) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic flash(logic er, logic [WORD_W-1:0] d);
    @(posedge clk);
    eraseEn <= er;
    progEn <= !er;
    progAddr <= SEC_WORD_ADDR;
    progData <= d;
    @(posedge clk);
    eraseEn <= 1'b0;
    progEn <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic look(logic s, logic [WORD_W-1:0] d);
    chk("secured", {17'h0, secured}, {17'h0, s});
    chk("sampled", {17'h0, secValid}, 18'h00001);
    i_host.rd(SEC_WORD_ADDR, r);
    chk("answer", r, {1'b1, s, s ? 16'h0000 : d});
  endtask
  task automatic tLock;
    flash(1'b1, '0);
    look(1'b0, ERASED_WORD);
    flash(1'b0, SEC_CODE_SECURED);
    look(1'b1, '0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("reset lock", {16'h0, secured, secValid}, 18'h00002);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    look(1'b1, '0);
    $display("lock test done");
  endtask
  task automatic tOpen;
    flash(1'b0, SEC_CODE_UNSECURED);
    look(1'b0, SEC_CODE_UNSECURED);
    flash(1'b0, ERASED_WORD);
    look(1'b0, SEC_CODE_UNSECURED);
    flash(1'b1, '0);
    flash(1'b0, 16'h0003);
    look(1'b0, 16'h0003);
    flash(1'b0, SEC_CODE_SECURED);
    look(1'b1, '0);
    $display("open test done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    tLock;
    tOpen;
    results;
  end
  initial begin
    #100000;
    badCount++;
    results;
  end
endmodule // tb_top
`default_nettype wire
